/* File: rtl/sar_adc_ctrl.sv */
// Converter control: Avalon-MM registers, triggers, SAR clock, sequencer, result format
`timescale 1ns/1ns
`default_nettype none
`include "sar_adc_cfg.svh"

module sar_adc_ctrl #(
  parameter int RESULT_W = 10,   // Converter resolution
  parameter int DIV_W    = 5     // Divider field width
) (
  input  wire logic                   core_clk,
  input  wire logic                   sys_rst,
  input  wire logic                   clk_en,
  // Avalon-MM slave
  input  wire logic [3:0]             avs_address,
  input  wire logic                   avs_read,
  input  wire logic                   avs_write,
  input  wire logic [3:0]             avs_byteenable,
  input  wire logic [31:0]            avs_writedata,
  output logic      [31:0]            avs_readdata,
  output logic                        avs_waitrequest,
  // Trigger sources
  input  wire sar_adc_pkg::timer_events_t timer_events,
  input  wire logic                   start_pin,
  // Analog core
  input  wire logic [RESULT_W-1:0]    adc_code,
  output logic                        sar_clk,
  output logic                        track,
  output logic                        shutdown,
  output logic                        gain_select,
  output logic                        irq_req
);

  // Elaboration check: the formatting logic is built for ten bits and a five-bit divider
  if (RESULT_W != 10 || DIV_W != 5) begin : g_bad_param
    $error("sar_adc_ctrl supports RESULT_W=10 and DIV_W=5 only");
  end

  // Register read decode, used for the read path
  function automatic logic [7:0] reg_read(input logic [3:0] addr, input logic [7:0] ctl,
                                          input logic [7:0] cfg, input logic [7:0] hi,
                                          input logic [7:0] lo);
    logic [7:0] val;
    val = 8'h00;
    case (addr)
      `OFS_CONTROL:     val = ctl;
      `OFS_CONFIG:      val = cfg;
      `OFS_RESULT_HIGH: val = hi;
      `OFS_RESULT_LOW:  val = lo;
      default:          val = 8'h00;
    endcase
    return val;
  endfunction : reg_read

  // Conversion length for the current width
  function automatic logic [4:0] conv_cycles(input logic eight_bit);
    return eight_bit ? `CYC_EIGHT_BIT : `CYC_TEN_BIT;
  endfunction : conv_cycles

  // Bus handshake state
  logic        waitreq_ff;      // Waitrequest, high until the answer cycle
  logic [31:0] rdata_ff;        // Read data held for the master
  logic        nxt_waitreq;
  logic [31:0] nxt_rdata;

  // Control and config fields
  logic        enable_ff;       // Converter enable
  logic        delayed_ff;      // Delayed tracking mode
  logic        complete_ff;     // Conversion complete flag
  logic        irq_en_ff;       // Interrupt enable
  logic [2:0]  source_ff;       // Start source select
  sar_adc_pkg::conv_config_t cfg_ff;  // Divider, justify, width, gain
  logic [7:0]  res_high_ff;     // Result high byte
  logic [7:0]  res_low_ff;      // Result low byte
  logic        nxt_enable;
  logic        nxt_delayed;
  logic        nxt_complete;
  logic        nxt_irq_en;
  logic [2:0]  nxt_source;
  sar_adc_pkg::conv_config_t nxt_cfg;
  logic [7:0]  nxt_res_high;
  logic [7:0]  nxt_res_low;

  // Sequencer state
  sar_adc_pkg::conv_state_t state_ff;  // Idle, delay or convert
  sar_adc_pkg::conv_state_t nxt_state;
  logic [DIV_W-1:0] div_cnt_ff;  // System clock count inside one SAR cycle
  logic [DIV_W-1:0] nxt_div_cnt;
  logic [4:0]  sar_cnt_ff;       // SAR cycles left in the current phase
  logic [4:0]  nxt_sar_cnt;
  logic        sar_clk_ff;       // SAR clock out
  logic        nxt_sar_clk;
  logic        track_ff;         // Track-and-hold in tracking
  logic        nxt_track;
  logic        shutdown_ff;      // Low power shutdown
  logic        nxt_shutdown;
  logic        irq_ff;           // Interrupt request level
  logic        nxt_irq;

  // Start pin synchroniser and edge history
  logic        pin_meta_ff;      // First stage, read only by the second
  logic        pin_sync_ff;      // Second stage
  logic        pin_prev_ff;      // Previous synchronised level

  // Bus, trigger and sequencer helpers
  logic        bus_req;          // Any request present
  logic        wr_commit;        // Write takes effect this edge
  logic        sw_start;         // Software launch request
  logic        trigger;          // Selected trigger fired
  logic        sar_tick;         // Last system clock of a SAR cycle
  logic        busy;             // Conversion in progress
  logic [7:0]  ctl_view;         // Control register as read
  logic [7:0]  cfg_view;         // Config register as read

  assign bus_req   = avs_read | avs_write;
  assign wr_commit = avs_write & ~waitreq_ff & avs_byteenable[0];
  assign busy      = (state_ff != sar_adc_pkg::ST_IDLE);
  assign sar_tick  = (div_cnt_ff == cfg_ff.divider);

  assign ctl_view = {enable_ff, delayed_ff, complete_ff, busy, irq_en_ff, source_ff};
  assign cfg_view = {cfg_ff.divider, cfg_ff.justify, cfg_ff.eight_bit, cfg_ff.gain};

  // Software start: a written one in the busy bit while the software source applies
  assign sw_start = wr_commit && (avs_address == `OFS_CONTROL)
                    && avs_writedata[`CTL_BUSY_BIT]
                    && (source_ff == `SRC_SOFTWARE);

  // Trigger selection, split timers use their low byte overflow
  always_comb begin
    case (source_ff)
      `SRC_SOFTWARE: trigger = sw_start;
      `SRC_TIMER0:   trigger = timer_events.timer0_ovf;
      `SRC_TIMER2:   trigger = timer_events.timer2_split ? timer_events.timer2_low_ovf
                                                         : timer_events.timer2_ovf;
      `SRC_TIMER1:   trigger = timer_events.timer1_ovf;
      `SRC_PIN:      trigger = pin_sync_ff & ~pin_prev_ff;
      `SRC_TIMER3:   trigger = timer_events.timer3_split ? timer_events.timer3_low_ovf
                                                         : timer_events.timer3_ovf;
      default:       trigger = 1'b0;
    endcase
  end

  // Bus next state: one wait cycle, then the answer cycle
  always_comb begin
    nxt_waitreq = 1'b1;
    nxt_rdata   = rdata_ff;
    if (bus_req && waitreq_ff) begin
      // Accept: answer in the next cycle
      nxt_waitreq = 1'b0;
      nxt_rdata   = {24'h00_0000, reg_read(avs_address, ctl_view, cfg_view,
                                           res_high_ff, res_low_ff)};
    end
  end

  // Register and sequencer next state
  always_comb begin
    nxt_enable   = enable_ff;
    nxt_delayed  = delayed_ff;
    nxt_complete = complete_ff;
    nxt_irq_en   = irq_en_ff;
    nxt_source   = source_ff;
    nxt_cfg      = cfg_ff;
    nxt_res_high = res_high_ff;
    nxt_res_low  = res_low_ff;
    nxt_state    = state_ff;
    nxt_div_cnt  = sar_tick ? '0 : div_cnt_ff + 1'b1;
    nxt_sar_cnt  = sar_cnt_ff;

    // Software writes to the low byte of each register
    if (wr_commit) begin
      case (avs_address)
        `OFS_CONTROL: begin
          nxt_enable   = avs_writedata[`CTL_ENABLE_BIT];
          nxt_delayed  = avs_writedata[`CTL_DELAYED_BIT];
          nxt_complete = avs_writedata[`CTL_COMPLETE_BIT];
          nxt_irq_en   = avs_writedata[`CTL_IRQ_EN_BIT];
          nxt_source   = avs_writedata[`CTL_SOURCE_MSB:`CTL_SOURCE_LSB];
        end
        `OFS_CONFIG: begin
          nxt_cfg.divider   = avs_writedata[`CFG_DIV_MSB:`CFG_DIV_LSB];
          nxt_cfg.justify   = avs_writedata[`CFG_JUSTIFY_BIT];
          nxt_cfg.eight_bit = avs_writedata[`CFG_EIGHT_BIT];
          nxt_cfg.gain      = avs_writedata[`CFG_GAIN_BIT];
        end
        `OFS_RESULT_HIGH: nxt_res_high = avs_writedata[7:0];
        `OFS_RESULT_LOW:  nxt_res_low  = avs_writedata[7:0];
        default: begin
          // Unmapped: write ignored
        end
      endcase
    end

    // Sequencer
    case (state_ff)
      sar_adc_pkg::ST_IDLE: begin
        if (enable_ff && trigger) begin
          nxt_div_cnt = '0;
          if (delayed_ff) begin
            nxt_state   = sar_adc_pkg::ST_DELAY;
            nxt_sar_cnt = `CYC_DELAY_TRACK;
          end else begin
            nxt_state   = sar_adc_pkg::ST_CONVERT;
            nxt_sar_cnt = conv_cycles(cfg_ff.eight_bit);
          end
        end
      end
      sar_adc_pkg::ST_DELAY: begin
        // Extra tracking cycles; new triggers ignored
        if (sar_tick) begin
          if (sar_cnt_ff == 5'h01) begin
            nxt_state   = sar_adc_pkg::ST_CONVERT;
            nxt_sar_cnt = conv_cycles(cfg_ff.eight_bit);
          end else begin
            nxt_sar_cnt = sar_cnt_ff - 5'h01;
          end
        end
      end
      sar_adc_pkg::ST_CONVERT: begin
        if (sar_tick) begin
          if (sar_cnt_ff == 5'h01) begin
            // End of conversion: load bytes, set complete flag
            nxt_state    = sar_adc_pkg::ST_IDLE;
            nxt_complete = 1'b1;
            if (cfg_ff.eight_bit) begin
              nxt_res_high = adc_code[9:2];
              nxt_res_low  = 8'h00;
            end else if (cfg_ff.justify) begin
              nxt_res_high = adc_code[9:2];
              nxt_res_low  = {adc_code[1:0], 6'h00};
            end else begin
              nxt_res_high = {6'h00, adc_code[9:8]};
              nxt_res_low  = adc_code[7:0];
            end
          end else begin
            nxt_sar_cnt = sar_cnt_ff - 5'h01;
          end
        end
      end
      default: nxt_state = sar_adc_pkg::ST_IDLE;
    endcase

    // Disabled converter abandons any conversion
    if (!enable_ff) begin
      nxt_state   = sar_adc_pkg::ST_IDLE;
      nxt_div_cnt = '0;
    end
  end

  // Output next values
  always_comb begin
    nxt_sar_clk = 1'b0;
    nxt_track   = 1'b0;
    if (nxt_state != sar_adc_pkg::ST_IDLE) begin
      // SAR clock high in the first half of each SAR cycle; with a zero divider
      // the SAR cycle is one system clock, so this flopped copy stays low
      nxt_sar_clk = ({1'b0, nxt_div_cnt} < ({1'b0, cfg_ff.divider} + 6'h01) >> 1);
    end
    if (nxt_enable && nxt_state != sar_adc_pkg::ST_CONVERT) begin
      if (nxt_source != `SRC_PIN) begin
        nxt_track = 1'b1;
      end else begin
        nxt_track = nxt_delayed || !pin_sync_ff;
      end
    end
    nxt_irq = nxt_complete & nxt_irq_en;
    nxt_shutdown = ~nxt_enable;
  end

  // Control reset byte; each field takes its own bits
  localparam logic [7:0] CTL_RST = `CONTROL_RESET;

  // Bus handshake registers; clock enable freezes them
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      waitreq_ff <= 1'b1;
      rdata_ff   <= 32'h0000_0000;
    end else if (clk_en) begin
      waitreq_ff <= nxt_waitreq;
      rdata_ff   <= nxt_rdata;
    end
  end

  // Register fields and sequencer state
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      enable_ff   <= CTL_RST[`CTL_ENABLE_BIT];
      delayed_ff  <= CTL_RST[`CTL_DELAYED_BIT];
      complete_ff <= CTL_RST[`CTL_COMPLETE_BIT];
      irq_en_ff   <= CTL_RST[`CTL_IRQ_EN_BIT];
      source_ff   <= CTL_RST[`CTL_SOURCE_MSB:`CTL_SOURCE_LSB];
      cfg_ff      <= `CONFIG_RESET;
      res_high_ff <= `RESULT_RESET;
      res_low_ff  <= `RESULT_RESET;
      state_ff    <= sar_adc_pkg::ST_IDLE;
      div_cnt_ff  <= '0;
      sar_cnt_ff  <= 5'h00;
    end else if (clk_en) begin
      enable_ff   <= nxt_enable;
      delayed_ff  <= nxt_delayed;
      complete_ff <= nxt_complete;
      irq_en_ff   <= nxt_irq_en;
      source_ff   <= nxt_source;
      cfg_ff      <= nxt_cfg;
      res_high_ff <= nxt_res_high;
      res_low_ff  <= nxt_res_low;
      state_ff    <= nxt_state;
      div_cnt_ff  <= nxt_div_cnt;
      sar_cnt_ff  <= nxt_sar_cnt;
    end
  end

  // Analog-facing outputs and interrupt level
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sar_clk_ff  <= 1'b0;
      track_ff    <= 1'b0;
      shutdown_ff <= 1'b1;
      irq_ff      <= 1'b0;
    end else if (clk_en) begin
      sar_clk_ff  <= nxt_sar_clk;
      track_ff    <= nxt_track;
      shutdown_ff <= nxt_shutdown;
      irq_ff      <= nxt_irq;
    end
  end

  // Start pin synchroniser; only the second stage reads the first
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pin_meta_ff <= 1'b0;
      pin_sync_ff <= 1'b0;
      pin_prev_ff <= 1'b0;
    end else if (clk_en) begin
      pin_meta_ff <= start_pin;
      pin_sync_ff <= pin_meta_ff;
      pin_prev_ff <= pin_sync_ff;
    end
  end

  // Outputs straight from flip-flops
  assign avs_readdata    = rdata_ff;
  assign avs_waitrequest = waitreq_ff;
  assign sar_clk         = sar_clk_ff;
  assign track           = track_ff;
  assign shutdown        = shutdown_ff;
  assign gain_select     = cfg_ff.gain;
  assign irq_req         = irq_ff;

endmodule : sar_adc_ctrl
`default_nettype wire

/* File: rtl/sar_adc_cfg.svh */
// Offsets, field positions, reset values and timing counts of the converter control
//
// Behaviour
// - Converter runs only while enable is one
// - Each conversion end loads high and low bytes
// - Justify select picks right or left layout
// - Bits without result data read as zero
// - Eight-bit mode: top eight bits, justify ignored
// - Eight-bit conversion ends two SAR cycles sooner
// - Ten-bit takes 13, eight-bit 11 cycles
// - SAR clock divided down from system clock
// - Five-bit divider holds sysclk over sarclk minus one
// - Start source picks one of six triggers
// - Software busy write launches one conversion
// - Busy high throughout conversion, cleared at end
// - Busy fall sets complete flag, optional interrupt
// - Split timers trigger on low byte overflow
// - Delayed tracking adds three SAR cycles first
// - Without delayed tracking conversion starts at once
// - Internal sources: track whenever enabled and not converting
// - Pin source: track if delayed or pin low
`ifndef SAR_ADC_CFG_SVH
`define SAR_ADC_CFG_SVH

// Register byte offsets on the bus
`define OFS_CONTROL        4'h0
`define OFS_CONFIG         4'h4
`define OFS_RESULT_HIGH    4'h8
`define OFS_RESULT_LOW     4'hC

// Control register field positions
`define CTL_ENABLE_BIT     7
`define CTL_DELAYED_BIT    6
`define CTL_COMPLETE_BIT   5
`define CTL_BUSY_BIT       4
`define CTL_IRQ_EN_BIT     3
`define CTL_SOURCE_MSB     2
`define CTL_SOURCE_LSB     0

// Config register field positions
`define CFG_DIV_MSB        7
`define CFG_DIV_LSB        3
`define CFG_JUSTIFY_BIT    2
`define CFG_EIGHT_BIT      1
`define CFG_GAIN_BIT       0

// Reset values
`define CONTROL_RESET      8'h00
`define CONFIG_RESET       8'hF9
`define RESULT_RESET       8'h00

// Start source encodings
`define SRC_SOFTWARE       3'h0
`define SRC_TIMER0         3'h1
`define SRC_TIMER2         3'h2
`define SRC_TIMER1         3'h3
`define SRC_PIN            3'h4
`define SRC_TIMER3         3'h5

// Timing counts in SAR clock cycles
`define CYC_TEN_BIT        5'h0D
`define CYC_EIGHT_BIT      5'h0B
`define CYC_DELAY_TRACK    5'h03

`endif

/* File: rtl/sar_adc_pkg.sv */
// Types shared by the converter control design
package sar_adc_pkg;

  // Conversion sequencer states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b001,
    ST_DELAY   = 3'b010,
    ST_CONVERT = 3'b100
  } conv_state_t;

  // Trigger inputs from the on-chip timers
  typedef struct packed {
    logic timer0_ovf;
    logic timer1_ovf;
    logic timer2_ovf;
    logic timer2_low_ovf;
    logic timer2_split;
    logic timer3_ovf;
    logic timer3_low_ovf;
    logic timer3_split;
  } timer_events_t;

  // Decoded config register
  typedef struct packed {
    logic [4:0] divider;
    logic       justify;
    logic       eight_bit;
    logic       gain;
  } conv_config_t;

endpackage : sar_adc_pkg

/* File: sim/sar_adc_core_model.sv */
// Behavioural analog core: holds the tracked input code for the conversion
`timescale 1ns/1ns
`default_nettype none
module sar_adc_core_model (
  input  wire logic       core_clk,
  input  wire logic       track,
  input  wire logic       shutdown,
  input  wire logic [9:0] code_set,
  output logic      [9:0] adc_code
);
  logic [9:0] held;  // Code captured while the input is tracked
  // The input follows the source only while the core tracks
  always_ff @(posedge core_clk) if (track) held <= code_set;
  // A powered-down core offers no valid code, so drive the inverse
  assign adc_code = shutdown ? ~held : held;
endmodule : sar_adc_core_model
`default_nettype wire

/* File: sim/sar_adc_ctrl_sva.sv */
// Port-level assertions for the converter control block
`timescale 1ns/1ns
`default_nettype none
module sar_adc_ctrl_sva #(
  parameter int RESULT_W = 10  // Converter resolution
) (
  input wire logic                       core_clk,
  input wire logic                       sys_rst,
  input wire logic                       clk_en,
  input wire logic [3:0]                 avs_address,
  input wire logic                       avs_read,
  input wire logic                       avs_write,
  input wire logic [3:0]                 avs_byteenable,
  input wire logic [31:0]                avs_writedata,
  input wire logic [31:0]                avs_readdata,
  input wire logic                       avs_waitrequest,
  input wire sar_adc_pkg::timer_events_t timer_events,
  input wire logic                       start_pin,
  input wire logic [RESULT_W-1:0]        adc_code,
  input wire logic                       sar_clk,
  input wire logic                       track,
  input wire logic                       shutdown,
  input wire logic                       gain_select,
  input wire logic                       irq_req
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // A register write is accepted in this cycle
  wire wr_ok = avs_write && !avs_waitrequest && clk_en && avs_byteenable[0];
  // A bus request still waiting for its answer
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest && clk_en;
  endsequence
  // One answer cycle, then the slave is busy again
  sequence s_answer;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  property p_rst_vals;
    disable iff (1'b0) sys_rst && clk_en |=>
      shutdown && avs_waitrequest && !sar_clk && !irq_req && gain_select;
  endproperty
  property p_off_quiet;
    shutdown && $past(shutdown) |-> !sar_clk;
  endproperty
  property p_enable_wr;
    wr_ok && avs_address == 4'h0 |=> shutdown == !$past(avs_writedata[7]);
  endproperty
  property p_gain_wr;
    wr_ok && avs_address == 4'h4 |=> gain_select == $past(avs_writedata[0]);
  endproperty
  property p_answer;
    s_req |=> s_answer;
  endproperty
  property p_upper_zero;
    avs_readdata[31:8] == 24'h00_0000;
  endproperty
  property p_unmapped;
    avs_read && !avs_waitrequest && avs_address[1:0] != 2'h0 |-> avs_readdata == 32'h0;
  endproperty
  property p_freeze;
    !clk_en |=> $stable(sar_clk) && $stable(track) && $stable(irq_req) && $stable(shutdown);
  endproperty
  a_rst_vals:   assert property (p_rst_vals) else $error("reset values wrong");
  a_off_quiet:  assert property (p_off_quiet) else $error("sar clock while off");
  a_enable_wr:  assert property (p_enable_wr) else $error("shutdown not enable");
  a_gain_wr:    assert property (p_gain_wr) else $error("gain select not updated");
  a_answer:     assert property (p_answer) else $error("bus answer timing wrong");
  a_upper_zero: assert property (p_upper_zero) else $error("upper read lanes set");
  a_unmapped:   assert property (p_unmapped) else $error("unmapped read not zero");
  a_freeze:     assert property (p_freeze) else $error("state moved while frozen");
endmodule : sar_adc_ctrl_sva
bind sar_adc_ctrl sar_adc_ctrl_sva #(.RESULT_W(RESULT_W)) u_sva (
  .core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .timer_events(timer_events), .start_pin(start_pin),
  .adc_code(adc_code), .sar_clk(sar_clk), .track(track), .shutdown(shutdown),
  .gain_select(gain_select), .irq_req(irq_req));
`default_nettype wire

/* File: sim/sar_adc_ctrl_tb_top.sv */
// Self-checking bench for the converter control block
`timescale 1ns/1ns
`default_nettype none
module sar_adc_ctrl_tb_top;
  logic                       core_clk, sys_rst, clk_en, avs_read, avs_write, start_pin;
  logic [3:0]                 avs_address, avs_byteenable;
  logic [31:0]                avs_writedata, avs_readdata;
  logic                       avs_waitrequest, sar_clk, track, shutdown, gain_select, irq_req;
  sar_adc_pkg::timer_events_t timer_events;
  logic [9:0]                 adc_code, code_set;
  logic [7:0]                 q, hi, lo;
  int                         err_count, n_compared, sar_rises, n, s;
  // Case tables: divider, justify, eight-bit, delay, code
  int         c_div[5] = '{1, 3, 1, 2, 4};
  logic       c_jst[5] = '{0, 1, 0, 1, 1};
  logic       c_eig[5] = '{0, 0, 1, 0, 1};
  logic       c_dly[5] = '{0, 0, 1, 1, 0};
  logic [9:0] c_code[5] = '{10'h3FF, 10'h3FF, 10'h2A5, 10'h201, 10'h155};
  // Trigger masks for sources 1..5, selected and unselected
  logic [7:0] ok_m[5] = '{8'h80, 8'h20, 8'h40, 8'h00, 8'h03};
  logic [7:0] bad_m[5] = '{8'h04, 8'h10, 8'h04, 8'h80, 8'h05};
  sar_adc_ctrl uut (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .timer_events(timer_events), .start_pin(start_pin), .adc_code(adc_code),
    .sar_clk(sar_clk), .track(track), .shutdown(shutdown), .gain_select(gain_select),
    .irq_req(irq_req));
  sar_adc_core_model core (.core_clk(core_clk), .track(track), .shutdown(shutdown),
    .code_set(code_set), .adc_code(adc_code));
  // 100 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Count SAR clock periods of a conversion
  always @(posedge sar_clk) sar_rises++;
  task automatic cmp8(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp8
  task automatic cmp_int(input string nm, input int e, input int g);
    n_compared++;
    if (g != e) begin
      err_count++;
      $display("CHECK FAILED %s expected %0d seen %0d", nm, e, g);
    end
  endtask : cmp_int
  // One Avalon transfer; returns one edge after the answer
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d,
                     input logic [3:0] be, output logic [7:0] r);
    avs_address <= a;
    avs_writedata <= {24'h00_0000, d};
    avs_byteenable <= be;
    avs_read <= !wr;
    avs_write <= wr;
    @(posedge core_clk);
    // Hold the request until waitrequest is seen low; the watchdog ends a hang
    while (avs_waitrequest !== 1'b0) @(posedge core_clk);
    r = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask : bus
  task automatic wr8(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'h1, q);
  endtask : wr8
  task automatic rd8(input logic [3:0] a, output logic [7:0] r);
    bus(1'b0, a, 8'h00, 4'h1, r);
  endtask : rd8
  // One-cycle timer event pulse
  task automatic pulse(input logic [7:0] m);
    timer_events <= m;
    @(posedge core_clk);
    timer_events <= '0;
    @(posedge core_clk);
  endtask : pulse
  // Edges from the trigger until the interrupt request is seen
  task automatic wait_done(input int init, output int cnt);
    cnt = init;
    while (irq_req !== 1'b1) begin
      @(posedge core_clk);
      cnt++;
    end
  endtask : wait_done
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  // Hang guard
  initial begin
    #300000;
    err_count++;
    wrap_up();
  end
  // Main sequence
  initial begin
    {sys_rst, clk_en} = 2'b11;
    {avs_read, avs_write, start_pin} = 3'b000;
    {avs_address, avs_byteenable, avs_writedata} = '0;
    timer_events = '0;
    code_set = 10'h000;
    {err_count, n_compared, sar_rises} = '0;
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    clk_en <= 1'b0;
    repeat (4) @(posedge core_clk);
    clk_en <= 1'b1;
    @(posedge core_clk);
    // Reset values and unmapped place
    rd8(4'h0, q); cmp8("control", 8'h00, q);
    rd8(4'h4, q); cmp8("config", 8'hF9, q);
    rd8(4'h8, q); cmp8("result high", 8'h00, q);
    rd8(4'hC, q); cmp8("result low", 8'h00, q);
    wr8(4'h6, 8'hFF);
    rd8(4'h6, q); cmp8("unmapped", 8'h00, q);
    bus(1'b1, 4'h4, 8'h00, 4'h0, q);
    rd8(4'h4, q); cmp8("config no lane", 8'hF9, q);
    cmp8("shutdown", 8'h01, {7'h0, shutdown});
    // Software starts over formats, dividers and tracking modes
    for (int i = 0; i < 5; i++) begin
      code_set <= c_code[i];
      wr8(4'h4, {c_div[i][4:0], c_jst[i], c_eig[i], 1'b1});
      wr8(4'h0, {1'b1, c_dly[i], 6'h08});
      sar_rises = 0;
      wr8(4'h0, {1'b1, c_dly[i], 6'h18});
      wait_done(1, n);
      s = (c_dly[i] ? 3 : 0) + (c_eig[i] ? 11 : 13);
      cmp_int("sar cycles", s, sar_rises);
      cmp_int("conv clocks", s * (c_div[i] + 1) + 1, n);
      rd8(4'h0, q); cmp8("control done", {1'b1, c_dly[i], 6'h28}, q);
      hi = c_eig[i] | c_jst[i] ? c_code[i][9:2] : {6'h00, c_code[i][9:8]};
      lo = c_eig[i] ? 8'h00 : c_jst[i] ? {c_code[i][1:0], 6'h00} : c_code[i][7:0];
      rd8(4'h8, q); cmp8("result high", hi, q);
      rd8(4'hC, q); cmp8("result low", lo, q);
      cmp8("track idle", 8'h01, {7'h0, track});
      wr8(4'h0, {1'b1, c_dly[i], 6'h08});
      cmp8("irq cleared", 8'h00, {7'h0, irq_req});
    end
    // Timer and pin sources, with unselected and repeated triggers
    wr8(4'h4, 8'h08);
    cmp8("gain select", 8'h00, {7'h0, gain_select});
    for (int k = 1; k <= 5; k++) begin
      wr8(4'h0, 8'h88 | k[7:0]);
      sar_rises = 0;
      pulse(bad_m[k-1]);
      repeat (20) @(posedge core_clk);
      cmp_int("unselected trigger", 0, sar_rises);
      if (k == 4) begin
        start_pin <= 1'b1;
        wait_done(0, n);
        cmp_int("pin start clocks", 13 * 2 + 4, n);
        cmp8("track pin high", 8'h00, {7'h0, track});
        start_pin <= 1'b0;
        repeat (6) @(posedge core_clk);
        cmp8("track pin low", 8'h01, {7'h0, track});
      end else begin
        pulse(ok_m[k-1]);
        pulse(ok_m[k-1]);
        wait_done(3, n);
        cmp_int("retrigger clocks", 13 * 2 + 1, n);
      end
      cmp_int("source cycles", 13, sar_rises);
      wr8(4'h0, 8'h88 | k[7:0]);
    end
    // Clock enable low in mid-conversion stretches it by the frozen edges
    wr8(4'h0, 8'h88);
    sar_rises = 0;
    wr8(4'h0, 8'h98);
    clk_en <= 1'b0;
    repeat (5) @(posedge core_clk);
    clk_en <= 1'b1;
    wait_done(6, n);
    cmp_int("frozen clocks", 13 * 2 + 1 + 5, n);
    cmp_int("frozen cycles", 13, sar_rises);
    // Disabled converter ignores a start
    wr8(4'h0, 8'h08);
    sar_rises = 0;
    wr8(4'h0, 8'h18);
    repeat (40) @(posedge core_clk);
    cmp_int("off cycles", 0, sar_rises);
    cmp8("off irq", 8'h00, {7'h0, irq_req});
    wrap_up();
  end
endmodule : sar_adc_ctrl_tb_top
`default_nettype wire
